// *** hw/abce_pkg.sv ***
// package: constants, opcodes and carriers of the bit/call execution unit
`default_nettype none
package abce_pkg;

   // apb register byte addresses
   localparam logic [11:0] ABCE_WORK_ADDR   = 12'h000;
   localparam logic [11:0] ABCE_STATUS_ADDR = 12'h004;
   localparam logic [11:0] ABCE_PCHB_ADDR   = 12'h008;
   localparam logic [11:0] ABCE_PC_ADDR     = 12'h00C;
   localparam logic [11:0] ABCE_STACK_ADDR  = 12'h010;
   localparam logic [11:0] ABCE_SPTR_ADDR   = 12'h014;
   localparam logic [11:0] ABCE_FILE_BASE   = 12'h100;
   localparam logic [11:0] ABCE_FILE_MASK   = 12'hF00;

   // status field positions
   localparam int ABCE_C_BIT  = 0;
   localparam int ABCE_DC_BIT = 1;
   localparam int ABCE_Z_BIT  = 2;

   // sizes
   localparam int ABCE_DATA_W  = 8;
   localparam int ABCE_FADDR_W = 6;
   localparam int ABCE_FILE_N  = 64;
   localparam int ABCE_PC_W    = 10;
   localparam int ABCE_SPTR_W  = 3;

   // reset values
   localparam logic [7:0] ABCE_WORK_RST   = 8'h00;
   localparam logic [2:0] ABCE_STATUS_RST = 3'h0;
   localparam logic [7:0] ABCE_PCHB_RST   = 8'h00;
   localparam logic [9:0] ABCE_PC_RST     = 10'h000;
   localparam logic [7:0] ABCE_FILE_RST   = 8'h00;

   // executed operations
   typedef enum logic [3:0] {
      ABCE_OP_NOP,
      ABCE_OP_ADD_IMM_WITH_CARRY,
      ABCE_OP_ADD_IMMEDIATE,
      ABCE_OP_AND_WITH_FILE_REG,
      ABCE_OP_AND_IMMEDIATE,
      ABCE_OP_BIT_CLEAR,
      ABCE_OP_BIT_SET,
      ABCE_OP_TEST_CLEAR_SKIP,
      ABCE_OP_CALL
   } abce_op_e;

   // decoded instruction word from program memory
   typedef struct packed {
      abce_op_e   op;
      logic [7:0] literal;
      logic [5:0] faddr;
      logic [2:0] bitsel;
      logic       dest;
   } abce_instr_s;

   // apb request carrier
   typedef struct packed {
      logic        psel;
      logic        penable;
      logic        pwrite;
      logic [11:0] paddr;
      logic [31:0] pwdata;
   } abce_apb_req_s;

   // pipeline control state
   typedef enum logic [1:0] {
      ABCE_ST_RUN,
      ABCE_ST_CALL2,
      ABCE_ST_SKIP
   } abce_state_e;

endpackage
`default_nettype wire

// *** hw/abce_exec.sv ***
// bit, add, and, skip and call execution unit with apb register access
//
// The register addresses and the APB register port were left to the implementer.
`default_nettype none
module abce_exec
   import abce_pkg::*;
(
   // clock and reset
   input  wire logic            clk,
   input  wire logic            rst_n,
   // instruction stream from program memory
   input  wire logic            instr_valid,
   input  wire abce_instr_s     instr,
   output logic                 instr_ready,
   output logic [9:0]           pc,
   // apb slave
   input  wire abce_apb_req_s   apb_req,
   output logic                 pready,
   output logic [31:0]          prdata,
   output logic                 pslverr
);

   ////////////////////////////////////////////////////////////////////////
   // state
   logic [7:0]        work_register_r;
   logic [2:0]        status_r;
   logic [7:0]        pc_high_buffer_r;
   logic [9:0]        pc_r;
   logic [9:0]        stack_top_r;
   logic [2:0]        stack_ptr_r;
   abce_state_e       state_r;
   logic [7:0]        file_r [ABCE_FILE_N];
   logic [31:0]       prdata_r;
   logic              pslverr_r;

   // execution decode
   logic              exec_go;
   logic              fire;
   logic [7:0]        file_rd;
   logic              bit_val;
   logic              cin;
   logic [8:0]        sum;
   logic [4:0]        nib_sum;
   logic [7:0]        and_res;
   logic [7:0]        bit_mask;
   logic              work_wr;
   logic [7:0]        work_wr_data;
   logic              file_wr;
   logic [7:0]        file_wr_data;
   logic              flags_wr;
   logic [2:0]        flags_nxt;

   // apb decode
   logic              apb_setup;
   logic              apb_wr;
   logic              addr_file;
   logic [5:0]        apb_idx;
   logic              sel_work;
   logic              sel_status;
   logic              sel_pchb;
   logic              sel_pc;
   logic              sel_stack;
   logic              sel_sptr;
   logic              sel_file;
   logic              sel_none;

   ////////////////////////////////////////////////////////////////////////
   // instruction acceptance

   // a new word is taken only in run state or as the discarded slot of a skip
   assign instr_ready = (state_r != ABCE_ST_CALL2);
   assign fire        = instr_valid && instr_ready;
   assign exec_go     = fire && (state_r == ABCE_ST_RUN);
   assign pc          = pc_r;

   // operands
   always_comb begin
      file_rd  = file_r[instr.faddr];
      bit_val  = file_rd[instr.bitsel];
      bit_mask = 8'h01 << instr.bitsel;
      cin      = (instr.op == ABCE_OP_ADD_IMM_WITH_CARRY) && status_r[ABCE_C_BIT];
      sum      = {1'b0, work_register_r} + {1'b0, instr.literal} + {8'h00, cin};
      nib_sum  = {1'b0, work_register_r[3:0]} + {1'b0, instr.literal[3:0]} + {4'h0, cin};
      if (instr.op == ABCE_OP_AND_WITH_FILE_REG) begin
         and_res = work_register_r & file_rd;
      end else begin
         and_res = work_register_r & instr.literal;
      end
   end

   // result routing and flag update
   always_comb begin
      work_wr      = 1'b0;
      work_wr_data = work_register_r;
      file_wr      = 1'b0;
      file_wr_data = file_rd;
      flags_wr     = 1'b0;
      flags_nxt    = status_r;
      if (exec_go) begin
         case (instr.op)
            ABCE_OP_ADD_IMM_WITH_CARRY, ABCE_OP_ADD_IMMEDIATE: begin
               work_wr                = 1'b1;
               work_wr_data           = sum[7:0];
               flags_wr               = 1'b1;
               flags_nxt[ABCE_C_BIT]  = sum[8];
               flags_nxt[ABCE_DC_BIT] = nib_sum[4];
               flags_nxt[ABCE_Z_BIT]  = (sum[7:0] == 8'h00);
            end
            ABCE_OP_AND_WITH_FILE_REG, ABCE_OP_AND_IMMEDIATE: begin
               if ((instr.op == ABCE_OP_AND_WITH_FILE_REG) && instr.dest) begin
                  file_wr      = 1'b1;
                  file_wr_data = and_res;
               end else begin
                  work_wr      = 1'b1;
                  work_wr_data = and_res;
               end
               flags_wr              = 1'b1;
               flags_nxt[ABCE_Z_BIT] = (and_res == 8'h00);
            end
            ABCE_OP_BIT_CLEAR: begin
               file_wr      = 1'b1;
               file_wr_data = file_rd & ~bit_mask;
            end
            ABCE_OP_BIT_SET: begin
               file_wr      = 1'b1;
               file_wr_data = file_rd | bit_mask;
            end
            default: begin
               file_wr = 1'b0;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // sequencing: pc, call stack and two-cycle states

   // control state; the slot after a taken skip or a call is spent idle
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_r <= ABCE_ST_RUN;
      end else begin
         case (state_r)
            ABCE_ST_RUN: begin
               if (exec_go && (instr.op == ABCE_OP_CALL)) begin
                  state_r <= ABCE_ST_CALL2;
               end else if (exec_go && (instr.op == ABCE_OP_TEST_CLEAR_SKIP) && !bit_val) begin
                  state_r <= ABCE_ST_SKIP;
               end
            end
            ABCE_ST_CALL2: begin
               state_r <= ABCE_ST_RUN;
            end
            ABCE_ST_SKIP: begin
               if (fire) begin
                  state_r <= ABCE_ST_RUN;
               end
            end
            default: begin
               state_r <= ABCE_ST_RUN;
            end
         endcase
      end
   end

   // program counter: steps per taken word, jumps on call
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pc_r <= ABCE_PC_RST;
      end else if (exec_go && (instr.op == ABCE_OP_CALL)) begin
         pc_r <= {pc_high_buffer_r[1:0], instr.literal};
      end else if (fire) begin
         pc_r <= pc_r + 10'h001;
      end
   end

   // return address push
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         stack_top_r <= ABCE_PC_RST;
         stack_ptr_r <= 3'h0;
      end else if (exec_go && (instr.op == ABCE_OP_CALL)) begin
         stack_top_r <= pc_r + 10'h001;
         stack_ptr_r <= stack_ptr_r + 3'h1;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // apb slave: zero wait, read data captured in the setup cycle

   assign apb_setup = apb_req.psel && !apb_req.penable;
   assign apb_wr    = apb_req.psel && apb_req.penable && apb_req.pwrite;
   assign addr_file = ((apb_req.paddr & ABCE_FILE_MASK) == ABCE_FILE_BASE) &&
                      (apb_req.paddr[1:0] == 2'b00);
   assign apb_idx   = apb_req.paddr[7:2];
   assign pready    = apb_req.psel && apb_req.penable;
   assign prdata    = prdata_r;
   assign pslverr   = pslverr_r & pready;

   // one-hot register select from the bus address; anything else is unmapped
   always_comb begin
      sel_work   = 1'b0;
      sel_status = 1'b0;
      sel_pchb   = 1'b0;
      sel_pc     = 1'b0;
      sel_stack  = 1'b0;
      sel_sptr   = 1'b0;
      sel_file   = 1'b0;
      sel_none   = 1'b0;
      if (apb_req.paddr == ABCE_WORK_ADDR) begin
         sel_work = 1'b1;
      end else if (apb_req.paddr == ABCE_STATUS_ADDR) begin
         sel_status = 1'b1;
      end else if (apb_req.paddr == ABCE_PCHB_ADDR) begin
         sel_pchb = 1'b1;
      end else if (apb_req.paddr == ABCE_PC_ADDR) begin
         sel_pc = 1'b1;
      end else if (apb_req.paddr == ABCE_STACK_ADDR) begin
         sel_stack = 1'b1;
      end else if (apb_req.paddr == ABCE_SPTR_ADDR) begin
         sel_sptr = 1'b1;
      end else if (addr_file) begin
         sel_file = 1'b1;
      end else begin
         sel_none = 1'b1;
      end
   end

   // read mux and error decode
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         prdata_r  <= 32'h0000_0000;
         pslverr_r <= 1'b0;
      end else if (apb_setup) begin
         pslverr_r <= sel_none; // unmapped address errors
         if (sel_work) begin
            prdata_r <= {24'h00_0000, work_register_r};
         end else if (sel_status) begin
            prdata_r <= {29'h0000_0000, status_r};
         end else if (sel_pchb) begin
            prdata_r <= {24'h00_0000, pc_high_buffer_r};
         end else if (sel_pc) begin
            prdata_r <= {22'h00_0000, pc_r};
         end else if (sel_stack) begin
            prdata_r <= {22'h00_0000, stack_top_r};
         end else if (sel_sptr) begin
            prdata_r <= {29'h0000_0000, stack_ptr_r};
         end else if (sel_file) begin
            prdata_r <= {24'h00_0000, file_r[apb_idx]};
         end else begin
            prdata_r <= 32'h0000_0000;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // architectural registers; an executing instruction wins over apb

   // work register
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         work_register_r <= ABCE_WORK_RST;
      end else if (work_wr) begin
         work_register_r <= work_wr_data;
      end else if (apb_wr && sel_work) begin
         work_register_r <= apb_req.pwdata[7:0];
      end
   end

   // status flags; bit ops, skip and call leave them alone
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         status_r <= ABCE_STATUS_RST;
      end else if (flags_wr) begin
         status_r <= flags_nxt;
      end else if (apb_wr && sel_status) begin
         status_r <= apb_req.pwdata[2:0];
      end
   end

   // program counter high buffer
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pc_high_buffer_r <= ABCE_PCHB_RST;
      end else if (apb_wr && sel_pchb) begin
         pc_high_buffer_r <= apb_req.pwdata[7:0];
      end
   end

   // file registers, one flip-flop byte per entry
   for (genvar gi = 0; gi < ABCE_FILE_N; gi++) begin : g_file
      always_ff @(posedge clk or negedge rst_n) begin
         if (!rst_n) begin
            file_r[gi] <= ABCE_FILE_RST;
         end else if (file_wr && (instr.faddr == 6'(gi))) begin
            file_r[gi] <= file_wr_data;
         end else if (apb_wr && sel_file && (apb_idx == 6'(gi))) begin
            file_r[gi] <= apb_req.pwdata[7:0];
         end
      end
   end

endmodule
`default_nettype wire

// *** test/abce_exec_monitor.sv ***
// checker: instruction and apb port timing of the execution unit
`default_nettype none
module abce_exec_monitor
   import abce_pkg::*;
(
   // clock and reset
   input wire logic          clk,
   input wire logic          rst_n,
   // instruction port
   input wire logic          instr_valid,
   input wire abce_instr_s   instr,
   input wire logic          instr_ready,
   input wire logic [9:0]    pc,
   // apb port
   input wire abce_apb_req_s apb_req,
   input wire logic          pready,
   input wire logic [31:0]   prdata,
   input wire logic          pslverr
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   // taken word and taken call
   wire logic take = instr_valid & instr_ready;
   wire logic call = take & (instr.op == ABCE_OP_CALL);
   sequence s_call; call; endsequence
   sequence s_gap; !instr_ready ##1 instr_ready; endsequence
   ////////////////////
   chk_call_gap: assert property (s_call |=> s_gap)
      else $error("call refusal gap wrong");
   chk_call_target: assert property (s_call |=> pc[7:0] == $past(instr.literal))
      else $error("call target low byte wrong");
   chk_pc_step: assert property (take && !call |=> pc == $past(pc) + 10'h001)
      else $error("pc did not step by one");
   chk_pc_hold: assert property (!take |=> $stable(pc))
      else $error("pc moved without a taken word");
   chk_ready_cause: assert property ($fell(instr_ready) |-> $past(call))
      else $error("ready dropped without a call");
   chk_ready_back: assert property (!instr_ready |=> instr_ready)
      else $error("ready low longer than one cycle");
   chk_apb_wait: assert property (apb_req.psel && apb_req.penable |-> pready)
      else $error("access phase not answered");
   chk_apb_idle: assert property (!apb_req.psel |-> !pready)
      else $error("ready without selection");
endmodule
bind abce_exec abce_exec_monitor u_mon (.clk(clk), .rst_n(rst_n), .instr_valid(instr_valid),
   .instr(instr), .instr_ready(instr_ready), .pc(pc), .apb_req(apb_req), .pready(pready),
   .prdata(prdata), .pslverr(pslverr));
`default_nettype wire

// *** test/abce_prog_mem.sv ***
// partner: program memory handing instruction words to the unit
`default_nettype none
module abce_prog_mem
   import abce_pkg::*;
(
   // clock and reset
   input  wire logic   clk,
   input  wire logic   rst_n,
   // pacing: idle cycle after each taken word
   input  wire logic   slow,
   // instruction port
   input  wire logic   instr_ready,
   output logic        instr_valid,
   output abce_instr_s instr
);
   timeunit 1ns;
   timeprecision 1ns;
   abce_instr_s q[$];
   // pop taken word, offer next; idle word toggles so it never looks stale
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         instr_valid <= 1'b0;
         instr <= '0;
      end else begin
         if (instr_valid && instr_ready) begin
            q.delete(0);
            instr_valid <= (q.size() != 0) && !slow;
         end else begin
            instr_valid <= (q.size() != 0);
         end
         instr <= (q.size() != 0) ? q[0] : abce_instr_s'(~instr);
      end
   end
endmodule
`default_nettype wire

// *** test/abce_exec_tb_top.sv ***
// testbench: directed scenarios for the bit, add, and, skip and call unit
`default_nettype none
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin errors++; \
   $display("ERROR %0t got %h want %h", $time, a, b); end end
module abce_exec_tb_top
   import abce_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic          clk = 1'b0;
   logic          rst_n = 1'b0;
   logic          slow = 1'b0;
   logic          instr_valid;
   logic          instr_ready;
   abce_instr_s   instr;
   logic [9:0]    pc;
   abce_apb_req_s req = '0;
   logic          pready;
   logic          pslverr;
   logic [31:0]   prdata;
   logic [31:0]   rv;
   logic          re;
   int            errors = 0;
   int            check_count = 0;
   int            cyc = 0;
   always #50 clk = ~clk;
   abce_exec u_dut (.clk(clk), .rst_n(rst_n), .instr_valid(instr_valid), .instr(instr),
      .instr_ready(instr_ready), .pc(pc), .apb_req(req), .pready(pready),
      .prdata(prdata), .pslverr(pslverr));
   abce_prog_mem u_mem (.clk(clk), .rst_n(rst_n), .slow(slow), .instr_ready(instr_ready),
      .instr_valid(instr_valid), .instr(instr));
   ////////////////////
   // one apb transfer: setup, then access until pready
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge clk);
      req <= '{1'b1, 1'b0, w, a, d};
      @(posedge clk);
      req.penable <= 1'b1;
      do begin
         @(posedge clk);
      end while (pready !== 1'b1);
      rv = prdata;
      re = pslverr;
      req <= '0;
   endtask
   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      apb(1'b1, a, {24'h0, d});
   endtask
   task automatic rdc(input logic [11:0] a, input logic [31:0] x);
      apb(1'b0, a, 32'h0);
      `CHK(rv, x)
      `CHK(re, 1'b0)
   endtask
   function automatic logic [11:0] fr(input logic [5:0] n);
      return ABCE_FILE_BASE + {4'h0, n, 2'b00};
   endfunction
   task automatic put(input abce_op_e op, input logic [7:0] l, input logic [5:0] f,
      input logic [2:0] b, input logic d);
      u_mem.q.push_back('{op, l, f, b, d});
   endtask
   // wait until memory is drained, then let the last word settle
   task automatic run();
      while (u_mem.q.size() != 0) begin
         @(posedge clk);
      end
      repeat (3) @(posedge clk);
   endtask
   ////////////////////
   task automatic alu(input abce_op_e op, input logic [7:0] w, input logic [2:0] s,
      input logic [7:0] l, input logic [7:0] we, input logic [2:0] se);
      wr(ABCE_WORK_ADDR, w);
      wr(ABCE_STATUS_ADDR, {5'h0, s});
      put(op, l, 6'h00, 3'h0, 1'b0);
      run();
      rdc(ABCE_WORK_ADDR, {24'h0, we});
      rdc(ABCE_STATUS_ADDR, {29'h0, se});
   endtask
   task automatic t_arith();
      alu(ABCE_OP_ADD_IMMEDIATE, 8'h12, 3'h1, 8'h34, 8'h46, 3'h0);
      alu(ABCE_OP_ADD_IMM_WITH_CARRY, 8'h12, 3'h1, 8'h34, 8'h47, 3'h0);
      alu(ABCE_OP_ADD_IMM_WITH_CARRY, 8'hF8, 3'h1, 8'h07, 8'h00, 3'h7);
      alu(ABCE_OP_ADD_IMMEDIATE, 8'hFF, 3'h0, 8'h01, 8'h00, 3'h7);
      alu(ABCE_OP_ADD_IMMEDIATE, 8'h09, 3'h6, 8'h08, 8'h11, 3'h2);
      alu(ABCE_OP_AND_IMMEDIATE, 8'h5A, 3'h3, 8'hAF, 8'h0A, 3'h3);
      alu(ABCE_OP_AND_IMMEDIATE, 8'h5A, 3'h0, 8'hA5, 8'h00, 3'h4);
   endtask
   task automatic t_file_and();
      wr(fr(6'h05), 8'hAF);
      wr(ABCE_WORK_ADDR, 8'h5A);
      wr(ABCE_STATUS_ADDR, 8'h03);
      put(ABCE_OP_AND_WITH_FILE_REG, 8'h00, 6'h05, 3'h0, 1'b1);
      run();
      rdc(fr(6'h05), 32'h0A);
      rdc(ABCE_WORK_ADDR, 32'h5A);
      wr(fr(6'h3F), 8'h0F);
      wr(ABCE_WORK_ADDR, 8'hF0);
      put(ABCE_OP_AND_WITH_FILE_REG, 8'h00, 6'h3F, 3'h0, 1'b0);
      run();
      rdc(ABCE_WORK_ADDR, 32'h00);
      rdc(fr(6'h3F), 32'h0F);
      rdc(ABCE_STATUS_ADDR, 32'h07);
   endtask
   task automatic t_bits();
      wr(fr(6'h00), 8'h5A);
      wr(ABCE_STATUS_ADDR, 8'h05);
      put(ABCE_OP_BIT_CLEAR, 8'h00, 6'h00, 3'h3, 1'b0);
      run();
      rdc(fr(6'h00), 32'h52);
      put(ABCE_OP_BIT_SET, 8'h00, 6'h00, 3'h7, 1'b0);
      put(ABCE_OP_BIT_CLEAR, 8'h00, 6'h00, 3'h1, 1'b0);
      put(ABCE_OP_BIT_SET, 8'h00, 6'h00, 3'h0, 1'b0);
      run();
      rdc(fr(6'h00), 32'hD1);
      rdc(ABCE_STATUS_ADDR, 32'h05);
   endtask
   task automatic t_skip();
      logic [9:0] p;
      wr(fr(6'h01), 8'h5A);
      wr(ABCE_WORK_ADDR, 8'h00);
      apb(1'b0, ABCE_PC_ADDR, 32'h0);
      p = rv[9:0];
      slow <= 1'b1;
      put(ABCE_OP_TEST_CLEAR_SKIP, 8'h00, 6'h01, 3'h2, 1'b0);
      put(ABCE_OP_ADD_IMMEDIATE, 8'h01, 6'h00, 3'h0, 1'b0);
      put(ABCE_OP_ADD_IMMEDIATE, 8'h02, 6'h00, 3'h0, 1'b0);
      put(ABCE_OP_TEST_CLEAR_SKIP, 8'h00, 6'h01, 3'h3, 1'b0);
      put(ABCE_OP_ADD_IMMEDIATE, 8'h04, 6'h00, 3'h0, 1'b0);
      run();
      slow <= 1'b0;
      rdc(ABCE_WORK_ADDR, 32'h06);
      rdc(ABCE_PC_ADDR, {22'h0, p + 10'h005});
   endtask
   task automatic t_call();
      logic [9:0] p;
      wr(ABCE_PCHB_ADDR, 8'h06);
      wr(ABCE_WORK_ADDR, 8'h10);
      apb(1'b0, ABCE_PC_ADDR, 32'h0);
      p = rv[9:0];
      put(ABCE_OP_CALL, 8'h34, 6'h00, 3'h0, 1'b0);
      put(ABCE_OP_ADD_IMMEDIATE, 8'h01, 6'h00, 3'h0, 1'b0);
      run();
      rdc(ABCE_STACK_ADDR, {22'h0, p + 10'h001});
      rdc(ABCE_PC_ADDR, 32'h235);
      `CHK(pc, 10'h235)
      rdc(ABCE_SPTR_ADDR, 32'h1);
      rdc(ABCE_WORK_ADDR, 32'h11);
   endtask
   task automatic t_regs();
      rdc(ABCE_WORK_ADDR, {24'h0, ABCE_WORK_RST});
      apb(1'b1, 12'h018, 32'hFF);
      `CHK(re, 1'b1)
      apb(1'b0, 12'h018, 32'h0);
      `CHK(re, 1'b1)
      `CHK(rv, 32'h0)
   endtask
   ////////////////////
   task automatic summarize();
      $display("checks %0d errors %0d", check_count, errors);
      if (errors == 0 && check_count > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   // cycle ceiling cuts a hang short
   always @(posedge clk) begin
      cyc++;
      if (cyc == 3000) begin
         $display("ERROR %0t cycle ceiling reached", $time);
         errors++;
         summarize();
      end
   end
   initial begin
      repeat (6) @(posedge clk);
      rst_n <= 1'b1;
      t_regs();
      t_arith();
      t_file_and();
      t_bits();
      t_skip();
      t_call();
      summarize();
   end
endmodule
`default_nettype wire
